// [ufc_pkg.sv]
// shared constants and types of the uart flow control block
package ufc_pkg;
	localparam int FIFO_DEPTH = 64;
	localparam int CNT_W      = 7;
	localparam int OVERSAMPLE = 16;
	localparam int SAMP_W     = 4;

	localparam logic [CNT_W-1:0] LVL_ONE   = 7'h01;
	localparam logic [CNT_W-1:0] LVL_FULL  = 7'h40;
	localparam int               LVL_SHIFT = 2;
	// selectable trigger levels and the next lower level of each
	localparam logic [CNT_W-1:0] SEL_LVL [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
	localparam logic [CNT_W-1:0] SEL_LOW [4] = '{7'h01, 7'h08, 7'h10, 7'h38};

	localparam int EFR_AUTO_CTS = 7;
	localparam int EFR_AUTO_RTS = 6;
	localparam int EFR_SPECIAL  = 5;
	localparam int EFR_TXSW_HI  = 3;
	localparam int EFR_TXSW_LO  = 2;
	localparam int EFR_RXSW_HI  = 1;
	localparam int EFR_RXSW_LO  = 0;
	localparam int MCR_ANY      = 5;
	localparam int MCR_RTS      = 1;
	localparam int FCR_FIFO_EN  = 0;
	localparam int FCR_RX_HI    = 7;
	localparam int FCR_RX_LO    = 6;
	localparam int FCR_TX_HI    = 5;
	localparam int FCR_TX_LO    = 4;
	localparam int LVL_RX_HI    = 7;
	localparam int LVL_RX_LO    = 4;
	localparam int LVL_TX_HI    = 3;
	localparam int LVL_TX_LO    = 0;
	localparam int IER_PAUSE    = 5;

	localparam logic [1:0] SW_NONE   = 2'h0;
	localparam logic [1:0] SW_FIRST  = 2'h2;
	localparam logic [1:0] SW_SECOND = 2'h1;
	localparam logic [1:0] SW_BOTH   = 2'h3;

	localparam logic [5:0] IDENT_PAUSE = 6'h10;
	localparam logic [5:0] IDENT_NONE  = 6'h01;

	localparam logic [15:0] BAUD_ONE = 16'h0001;
	localparam logic [2:0]  WL_BASE  = 3'h4;

	typedef struct packed {
		logic [2:0] err;
		logic [7:0] data;
	} ufc_rx_entry_t;

	typedef struct packed {
		logic [7:0]  enhanced_feature_reg;
		logic [7:0]  modem_control_reg;
		logic [7:0]  flow_threshold_reg;
		logic [7:0]  programmable_trigger_reg;
		logic [7:0]  fifo_control_reg;
		logic [7:0]  interrupt_enable_reg;
		logic [15:0] divisor;
		logic [1:0]  word_len;
		logic [7:0]  pause_char_first;
		logic [7:0]  pause_char_second;
		logic [7:0]  resume_char_first;
		logic [7:0]  resume_char_second;
	} ufc_cfg_t;

	typedef enum logic [3:0] {
		TX_IDLE  = 4'b0001,
		TX_START = 4'b0010,
		TX_DATA  = 4'b0100,
		TX_STOP  = 4'b1000
	} ufc_tx_state_t;
endpackage

// [ufc_fifo.sv]
// parameterised fifo with registered read data
module ufc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [CW-1:0]    count
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr;
	logic [AW-1:0]    rptr;
	logic [CW-1:0]    mcount;
	logic [CW-1:0]    next_mcount;
	wire              push = in_valid & in_ready;
	wire              load = (mcount != '0) & (~out_valid | out_ready);
	wire              pop  = out_valid & out_ready;

	assign count       = mcount + CW'(out_valid);
	assign in_ready    = count < CW'(DEPTH);
	assign next_mcount = mcount + CW'(push) - CW'(load);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr      <= '0;
			rptr      <= '0;
			mcount    <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			wptr      <= push ? wptr + AW'(1) : wptr;
			rptr      <= load ? rptr + AW'(1) : rptr;
			mcount    <= next_mcount;
			out_valid <= load | (out_valid & ~pop);
			out_data  <= load ? mem[rptr] : out_data;
		end
	end
endmodule

// [ufc_flow.sv]
// uart flow control, trigger levels, fifos and transmitter
//
// Behaviour
// - transmit and receive fifos hold 64 characters; receive entries carry 3 error bits
// - baud generator divides the clock by a 16-bit divisor from 1 to 65535
// - after reset fifos are off so trigger levels act as one character
// - programmable trigger levels apply unless that register is zero
// - enhanced feature bits 7 and 6 enable automatic cts and rts
// - with automatic cts, a data character starts only while cts is low; flow characters do not wait for cts
// - with automatic cts, cts changes raise no host interrupt
// - automatic rts stays low below halt level, goes high once reached
// - after a halt, rts returns low when occupancy drains to resume level, or below the next lower level with a zero flow threshold register
// - zero flow threshold register selects the fifo control trigger levels
// - characters are still accepted after rts went high until the receive fifo holds 64
// - enhanced feature bits 3:2 choose which pause and resume characters are sent
// - enhanced feature bits 1:0 choose which characters the receiver compares
// - with modem control bit 5, any character other than a pause character resumes sending after a pause
// - special character sets pause interrupt, is stored, ident read clears it
// - a pause stops sending after the current character and raises interrupt
// - a resume restarts sending and withdraws the pause interrupt
// - pause characters are sent when occupancy passes the halt level
// - resume characters are sent when occupancy reaches the resume level, or drops below the next lower level with a zero flow threshold register
// - flow characters are framed like data, word length low bits only
// - pause interrupt reports identification code 01 0000 at level six
// - after reset rts and serial output are high
module ufc_flow
	import ufc_pkg::*;
#(
	parameter int DEPTH = ufc_pkg::FIFO_DEPTH
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire ufc_pkg::ufc_cfg_t      cfg,
	input  wire logic                   tx_in_valid,
	output logic                        tx_in_ready,
	input  wire logic [7:0]             tx_in_data,
	input  wire logic                   rx_char_valid,
	input  wire ufc_pkg::ufc_rx_entry_t rx_char,
	output logic                        rx_overrun,
	output logic                        rx_out_valid,
	input  wire logic                   rx_out_ready,
	output ufc_pkg::ufc_rx_entry_t      rx_out,
	input  wire logic                   ident_read,
	input  wire logic                   cts_n,
	output logic                        txd,
	output logic                        rts_n,
	output logic                        irq_n,
	output logic [5:0]                  ident_code,
	output logic                        pause_int,
	output logic                        cts_change,
	output logic                        tx_halted,
	output logic [ufc_pkg::CNT_W-1:0]   rx_count,
	output logic [ufc_pkg::CNT_W-1:0]   tx_count,
	output logic                        rx_trig_hit,
	output logic                        tx_trig_hit
);
	import ufc_pkg::*;

	logic          rst_q1;
	logic          srst_n;
	logic [2:0]    cts_q;
	logic          cts_n_s;
	logic [15:0]   bcnt;
	logic [SAMP_W-1:0] samp;
	logic [2:0]    bit_idx;
	logic [7:0]    shift;
	ufc_tx_state_t tx_state;
	ufc_tx_state_t next_tx_state;
	logic          rts_halt;
	logic          pause_sent;
	logic          flow_busy;
	logic          flow_is_pause;
	logic          flow_second;
	logic          seq_p1;
	logic          seq_r1;
	logic          int_special;
	logic          tx_fifo_valid;
	logic [7:0]    tx_fifo_data;
	logic          rx_in_ready;

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q1 <= 1'b0;
			srst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			srst_n <= rst_q1;
		end
	end

	// configuration decode
	wire       auto_cts = cfg.enhanced_feature_reg[EFR_AUTO_CTS];
	wire       auto_rts = cfg.enhanced_feature_reg[EFR_AUTO_RTS];
	wire       special  = cfg.enhanced_feature_reg[EFR_SPECIAL];
	wire [1:0] tx_mode  =
		cfg.enhanced_feature_reg[EFR_TXSW_HI:EFR_TXSW_LO];
	wire [1:0] rx_mode  =
		cfg.enhanced_feature_reg[EFR_RXSW_HI:EFR_RXSW_LO];
	wire       fifo_en  = cfg.fifo_control_reg[FCR_FIFO_EN];
	wire [1:0] rx_sel   = cfg.fifo_control_reg[FCR_RX_HI:FCR_RX_LO];
	wire [1:0] tx_sel   = cfg.fifo_control_reg[FCR_TX_HI:FCR_TX_LO];
	wire       tlr_zero = cfg.programmable_trigger_reg == '0;
	wire       tcr_zero = cfg.flow_threshold_reg == '0;

	// trigger levels
	wire [CNT_W-1:0] rx_prog = CNT_W'(
		cfg.programmable_trigger_reg[LVL_RX_HI:LVL_RX_LO]) << LVL_SHIFT;
	wire [CNT_W-1:0] tx_prog = CNT_W'(
		cfg.programmable_trigger_reg[LVL_TX_HI:LVL_TX_LO]) << LVL_SHIFT;
	wire [CNT_W-1:0] rx_trig = !fifo_en ? LVL_ONE :
		(tlr_zero ? SEL_LVL[rx_sel] : rx_prog);
	wire [CNT_W-1:0] tx_trig = !fifo_en ? LVL_ONE :
		(tlr_zero ? SEL_LVL[tx_sel] : tx_prog);
	assign rx_trig_hit = rx_count >= rx_trig;
	assign tx_trig_hit = (LVL_FULL - tx_count) >= tx_trig;

	// halt and resume levels
	wire [CNT_W-1:0] tcr_halt = CNT_W'(
		cfg.flow_threshold_reg[LVL_TX_HI:LVL_TX_LO]) << LVL_SHIFT;
	wire [CNT_W-1:0] tcr_res = CNT_W'(
		cfg.flow_threshold_reg[LVL_RX_HI:LVL_RX_LO]) << LVL_SHIFT;
	wire [CNT_W-1:0] halt_lvl = tcr_zero ? SEL_LVL[rx_sel] : tcr_halt;
	wire halt_hit   = rx_count >= halt_lvl;
	wire pass_halt  = rx_count > halt_lvl;
	wire resume_hit = tcr_zero ? (rx_count < SEL_LOW[rx_sel]) :
		(rx_count <= tcr_res);

	// receive character comparison
	wire [7:0] c     = rx_char.data;
	wire is_p1 = c == cfg.pause_char_first;
	wire is_p2 = c == cfg.pause_char_second;
	wire is_r1 = c == cfg.resume_char_first;
	wire is_r2 = c == cfg.resume_char_second;
	wire seq   = (rx_mode == SW_BOTH) &
		((tx_mode == SW_BOTH) | (tx_mode == SW_NONE));
	wire p_match = ((rx_mode == SW_FIRST) & is_p1) |
		((rx_mode == SW_SECOND) & is_p2) |
		((rx_mode == SW_BOTH) & ~seq & (is_p1 | is_p2)) |
		(seq & is_p2 & seq_p1);
	wire r_match = ((rx_mode == SW_FIRST) & is_r1) |
		((rx_mode == SW_SECOND) & is_r2) |
		((rx_mode == SW_BOTH) & ~seq & (is_r1 | is_r2)) |
		(seq & is_r2 & seq_r1);
	wire flow_chr = ((rx_mode == SW_FIRST) & (is_p1 | is_r1)) |
		((rx_mode == SW_SECOND) & (is_p2 | is_r2)) |
		((rx_mode == SW_BOTH) & (is_p1 | is_p2 | is_r1 | is_r2));
	wire sp_hit   = rx_char_valid & special & is_p2;
	wire pause_rx = rx_char_valid & ~sp_hit & p_match;
	wire any_res  = cfg.modem_control_reg[MCR_ANY] & tx_halted;
	wire resume_rx = rx_char_valid & ~pause_rx &
		((~sp_hit & r_match) | any_res);
	wire rx_in_valid = rx_char_valid & (sp_hit | ~flow_chr);

	// receive fifo, accepts while room remains even with rts high
	ufc_fifo #(
		.WIDTH ($bits(ufc_rx_entry_t)),
		.DEPTH (DEPTH),
		.CW    (CNT_W)
	) u_rx_fifo (
		.clk       (clk),
		.rst_n     (srst_n),
		.in_valid  (rx_in_valid),
		.in_ready  (rx_in_ready),
		.in_data   (rx_char),
		.out_valid (rx_out_valid),
		.out_ready (rx_out_ready),
		.out_data  (rx_out),
		.count     (rx_count)
	);

	// transmit launch decisions
	wire tx_idle     = tx_state == TX_IDLE;
	wire cts_ok      = ~auto_cts | ~cts_n_s;
	wire launch_flow = tx_idle & flow_busy;
	wire launch_data = tx_idle & ~flow_busy & tx_fifo_valid &
		~tx_halted & cts_ok;
	wire use_second  = flow_second | (tx_mode == SW_SECOND);
	wire [7:0] flow_char = flow_is_pause ?
		(use_second ? cfg.pause_char_second : cfg.pause_char_first) :
		(use_second ? cfg.resume_char_second : cfg.resume_char_first);
	wire [7:0] launch_char = launch_flow ? flow_char : tx_fifo_data;
	wire start_pause = ~flow_busy & (tx_mode != SW_NONE) &
		~pause_sent & pass_halt;
	wire start_res   = ~flow_busy & (tx_mode != SW_NONE) &
		pause_sent & resume_hit;

	ufc_fifo #(
		.WIDTH (8),
		.DEPTH (DEPTH),
		.CW    (CNT_W)
	) u_tx_fifo (
		.clk       (clk),
		.rst_n     (srst_n),
		.in_valid  (tx_in_valid),
		.in_ready  (tx_in_ready),
		.in_data   (tx_in_data),
		.out_valid (tx_fifo_valid),
		.out_ready (launch_data),
		.out_data  (tx_fifo_data),
		.count     (tx_count)
	);

	// baud tick and bit timing
	wire tick     = bcnt <= BAUD_ONE;
	wire bit_done = tick & (samp == SAMP_W'(OVERSAMPLE - 1));
	wire [2:0] last_bit = WL_BASE + 3'(cfg.word_len);

	always_comb begin
		next_tx_state = tx_state;
		case (tx_state)
			TX_IDLE: begin
				if (launch_flow | launch_data) begin
					next_tx_state = TX_START;
				end
			end
			TX_START: begin
				if (bit_done) begin
					next_tx_state = TX_DATA;
				end
			end
			TX_DATA: begin
				if (bit_done & (bit_idx == last_bit)) begin
					next_tx_state = TX_STOP;
				end
			end
			TX_STOP: begin
				if (bit_done) begin
					next_tx_state = TX_IDLE;
				end
			end
			default: next_tx_state = TX_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			bcnt     <= BAUD_ONE;
			samp     <= '0;
			tx_state <= TX_IDLE;
		end else begin
			bcnt     <= tick ? cfg.divisor : bcnt - BAUD_ONE;
			samp     <= tx_idle ? '0 : (tick ? samp + SAMP_W'(1) : samp);
			tx_state <= next_tx_state;
		end
	end

	// serial shifter, idle high
	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			txd     <= 1'b1;
			shift   <= '0;
			bit_idx <= '0;
		end else if (tx_idle & (launch_flow | launch_data)) begin
			txd     <= 1'b0;
			shift   <= launch_char;
			bit_idx <= '0;
		end else if (bit_done & (tx_state == TX_START)) begin
			txd     <= shift[0];
		end else if (bit_done & (tx_state == TX_DATA)) begin
			txd     <= (bit_idx == last_bit) ? 1'b1 : shift[1];
			shift   <= shift >> 1;
			bit_idx <= bit_idx + 3'h1;
		end
	end

	// software flow transmit sequencing
	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			flow_busy     <= 1'b0;
			flow_is_pause <= 1'b0;
			flow_second   <= 1'b0;
			pause_sent    <= 1'b0;
		end else if (launch_flow) begin
			flow_second <= (tx_mode == SW_BOTH) & ~flow_second;
			flow_busy   <= (tx_mode == SW_BOTH) & ~flow_second;
		end else if (start_pause | start_res) begin
			flow_busy     <= 1'b1;
			flow_is_pause <= start_pause;
			pause_sent    <= start_pause;
		end else if (tx_mode == SW_NONE) begin
			pause_sent <= 1'b0;
		end
	end

	// receive side flow state, a new set wins over a clear
	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			seq_p1      <= 1'b0;
			seq_r1      <= 1'b0;
			tx_halted   <= 1'b0;
			pause_int   <= 1'b0;
			int_special <= 1'b0;
		end else begin
			seq_p1 <= rx_char_valid ? is_p1 : seq_p1;
			seq_r1 <= rx_char_valid ? is_r1 : seq_r1;
			tx_halted <= pause_rx | (tx_halted & ~resume_rx);
			if ((pause_rx | sp_hit) &
				cfg.interrupt_enable_reg[IER_PAUSE]) begin
				pause_int   <= 1'b1;
				int_special <= sp_hit;
			end else if ((resume_rx & ~int_special) |
				(ident_read & int_special)) begin
				pause_int   <= 1'b0;
				int_special <= 1'b0;
			end
		end
	end

	assign irq_n      = ~pause_int;
	assign ident_code = pause_int ? IDENT_PAUSE : IDENT_NONE;

	// cts pin sync, change accepted when stages two and three agree
	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			cts_q      <= 3'h7;
			cts_n_s    <= 1'b1;
			cts_change <= 1'b0;
		end else begin
			cts_q      <= {cts_q[1:0], cts_n};
			cts_n_s    <= (cts_q[1] == cts_q[2]) ? cts_q[2] : cts_n_s;
			cts_change <= ~auto_cts & (cts_q[1] == cts_q[2]) &
				(cts_q[2] != cts_n_s);
		end
	end

	// rts control and overrun
	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			rts_halt   <= 1'b0;
			rts_n      <= 1'b1;
			rx_overrun <= 1'b0;
		end else begin
			rts_halt   <= halt_hit | (rts_halt & ~resume_hit);
			rts_n      <= auto_rts ? (halt_hit | (rts_halt & ~resume_hit)) :
				~cfg.modem_control_reg[MCR_RTS];
			rx_overrun <= rx_in_valid & ~rx_in_ready;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!srst_n);

	a_rts_halt_level: assert property (auto_rts & halt_hit |=> rts_n)
		else $error("rts low at halt level");
	a_rts_resume_lvl: assert property (auto_rts & $past(auto_rts) &
		rts_halt & resume_hit & ~halt_hit |=> !rts_n)
		else $error("rts not reasserted at resume level");
	a_cts_gates_tx: assert property (auto_cts & cts_n_s & tx_idle &
		~flow_busy |=> tx_idle)
		else $error("data started with cts inactive");
	a_halt_blocks_tx: assert property (tx_halted & tx_idle &
		~flow_busy |=> tx_idle)
		else $error("data sent while paused");
	a_special_stored: assert property (sp_hit & !tx_halted
		|-> rx_in_valid ##1 !tx_halted)
		else $error("special char mishandled");
	a_resume_clears_int: assert property (resume_rx & !int_special &
		!pause_rx & !sp_hit |=> !pause_int && !tx_halted)
		else $error("resume left interrupt or halt");
	a_cts_no_change: assert property (auto_cts & $past(auto_cts)
		|-> !cts_change)
		else $error("cts change reported under auto cts");
	a_trig_fifo_off: assert property (!fifo_en |->
		rx_trig == LVL_ONE && tx_trig == LVL_ONE)
		else $error("trigger not one with fifo off");
	a_pause_sent_lvl: assert property (start_pause & !launch_flow
		|=> flow_busy && flow_is_pause)
		else $error("pause char not queued");
	a_ident_pause: assert property (pause_int |-> !irq_n &&
		ident_code == IDENT_PAUSE)
		else $error("pause ident wrong");
	a_flow_framed: assert property (launch_flow |=>
		tx_state == TX_START && !txd)
		else $error("flow char not framed");

	c_rts_halt: cover property (auto_rts & $rose(rts_n));
	c_flow_pause: cover property (launch_flow & flow_is_pause);
	c_special: cover property (sp_hit);
	c_resume_any: cover property (resume_rx & any_res);
endmodule

// [ufc_remote.sv]
// remote uart model: decodes txd frames and drives cts
module ufc_remote (
	input  wire logic       clk,
	input  wire logic       txd,
	input  wire logic       stop_req,
	input  wire logic [1:0] word_len,
	output logic            cts_n,
	output logic      [7:0] got,
	output int              n_got
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy;
	int   i;

	initial begin
		cts_n = stop_req;
		busy = 1'b0;
		got = 8'h00;
		n_got = 0;
	end

	// cts only moves between frames, from the middle of a stop bit until the next start bit
	always @(posedge clk) begin
		if (!busy)
			cts_n <= stop_req;
	end

	// sample mid-bit, lsb first; bits past the word length read high
	initial begin
		forever begin
			@(negedge txd);
			busy = 1'b1;
			got = 8'hFF;
			repeat (8) @(posedge clk);
			for (i = 0; i < 5 + word_len; i++) begin
				repeat (16) @(posedge clk);
				got[i] = txd;
			end
			n_got++;
			repeat (16) @(posedge clk);
			busy = 1'b0;
		end
	end
endmodule

// [ufc_flow_tb.sv]
// self-checking bench of the uart flow control block
`define CHK(nm, e, g) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("BAD %s exp %h got %h", nm, e, g); \
	end \
end
module ufc_flow_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ufc_pkg::*;
	logic clk = 0, rst_n = 0, tx_in_valid = 0, rx_char_valid = 0;
	logic rx_out_ready = 0, ident_read = 0, stop_req = 1, cts_seen = 0;
	logic [7:0] tx_in_data = 8'h00, got, p, r;
	ufc_cfg_t      cfg;
	ufc_rx_entry_t rx_char = '0, rx_out;
	logic tx_in_ready, rx_overrun, rx_out_valid, cts_n, txd, rts_n, irq_n;
	logic pause_int, cts_change, tx_halted, rx_trig_hit, tx_trig_hit;
	logic [5:0]       ident_code;
	logic [CNT_W-1:0] rx_count, tx_count;
	int n_got, n_mismatch = 0, n_checks = 0, cyc = 0, s;

	ufc_flow uut (.clk(clk), .rst_n(rst_n), .cfg(cfg),
		.tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
		.tx_in_data(tx_in_data), .rx_char_valid(rx_char_valid),
		.rx_char(rx_char), .rx_overrun(rx_overrun),
		.rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
		.rx_out(rx_out), .ident_read(ident_read), .cts_n(cts_n),
		.txd(txd), .rts_n(rts_n), .irq_n(irq_n),
		.ident_code(ident_code), .pause_int(pause_int),
		.cts_change(cts_change), .tx_halted(tx_halted),
		.rx_count(rx_count), .tx_count(tx_count),
		.rx_trig_hit(rx_trig_hit), .tx_trig_hit(tx_trig_hit));
	ufc_remote remote (.clk(clk), .txd(txd), .stop_req(stop_req),
		.word_len(cfg.word_len), .cts_n(cts_n), .got(got), .n_got(n_got));

	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cts_change === 1'b1)
			cts_seen <= 1'b1;
		if (cyc == 40000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic base_cfg();
		cfg = '0; // hardware and software flow never together
		cfg.divisor = BAUD_ONE;
		cfg.word_len = 2'h3;
		cfg.pause_char_first = 8'h13;
		cfg.pause_char_second = 8'h93;
		cfg.resume_char_first = 8'h11;
		cfg.resume_char_second = 8'h91;
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask
	task automatic push(input logic [7:0] d);
		rx_char_valid = 1'b1;
		rx_char = '{err: 3'h0, data: d};
		@(negedge clk);
		rx_char_valid = 1'b0;
		@(negedge clk);
	endtask
	task automatic send(input logic [7:0] d);
		tx_in_valid = 1'b1;
		tx_in_data = d;
		@(negedge clk);
		tx_in_valid = 1'b0;
	endtask
	task automatic drain(input int tgt);
		int t;
		t = 0;
		rx_out_ready = 1'b1;
		while (rx_count > tgt && t < 200) begin
			@(negedge clk);
			t++;
		end
		rx_out_ready = 1'b0;
		@(negedge clk);
	endtask
	task automatic expect_byte(input logic [7:0] e);
		int t;
		t = 0;
		s = n_got;
		while (n_got == s && t < 3000) begin
			@(negedge clk);
			t++;
		end
		`CHK("byte seen", 1'b1, n_got != s)
		`CHK("remote byte", e, got)
	endtask
	task automatic quiet();
		s = n_got;
		repeat (300) @(negedge clk);
		`CHK("no byte", 1'b1, n_got == s)
	endtask

	task automatic t_reset();
		base_cfg();
		do_reset();
		`CHK("txd", 1'b1, txd)
		`CHK("rts_n", 1'b1, rts_n)
		`CHK("ident", IDENT_NONE, ident_code)
		`CHK("tx trig", 1'b1, tx_trig_hit)
		push(8'h55);
		`CHK("trig", 1'b1, rx_trig_hit)
		`CHK("count", 7'h01, rx_count)
		`CHK("rx valid", 1'b1, rx_out_valid)
		`CHK("rx out", 11'h055, rx_out)
		drain(0);
		`CHK("count", 7'h00, rx_count)
		cts_seen = 1'b0;
		stop_req = 1'b0;
		repeat (8) @(negedge clk);
		`CHK("cts change", 1'b1, cts_seen)
		stop_req = 1'b1;
		repeat (8) @(negedge clk);
		repeat (64) push(8'h40);
		`CHK("count", 7'h40, rx_count)
		rx_char_valid = 1'b1;
		@(negedge clk);
		rx_char_valid = 1'b0;
		`CHK("overrun", 1'b1, rx_overrun)
		$display("done reset");
	endtask
	task automatic t_cts();
		base_cfg();
		cfg.enhanced_feature_reg = 8'h80;
		do_reset();
		cts_seen = 1'b0;
		send(8'hA5);
		quiet();
		`CHK("tx count", 7'h01, tx_count)
		stop_req = 1'b0;
		expect_byte(8'hA5);
		`CHK("cts change", 1'b0, cts_seen)
		$display("done cts");
	endtask
	task automatic t_rts(input logic [7:0] thr);
		base_cfg();
		cfg.enhanced_feature_reg = 8'h40;
		cfg.fifo_control_reg = 8'h01;
		cfg.flow_threshold_reg = thr;
		do_reset();
		repeat (7) push(8'h20);
		`CHK("rts_n", 1'b0, rts_n)
		push(8'h21);
		`CHK("rts_n", 1'b1, rts_n)
		push(8'h22);
		`CHK("count", 7'h09, rx_count)
		drain(thr != 8'h00 ? 5 : 1);
		`CHK("rts_n", 1'b1, rts_n)
		drain(thr != 8'h00 ? 4 : 0);
		`CHK("rts_n", 1'b0, rts_n)
		$display("done rts");
	endtask
	task automatic t_sw_rx(input logic [1:0] m);
		base_cfg();
		cfg.enhanced_feature_reg = {6'h00, m};
		cfg.interrupt_enable_reg = 8'h20;
		p = m == SW_FIRST ? cfg.pause_char_first : cfg.pause_char_second;
		r = m == SW_FIRST ? cfg.resume_char_first : cfg.resume_char_second;
		do_reset();
		push(m == SW_FIRST ? cfg.pause_char_second : cfg.pause_char_first);
		`CHK("halted", 1'b0, tx_halted)
		push(p);
		`CHK("halted", 1'b1, tx_halted)
		`CHK("irq_n", 1'b0, irq_n)
		`CHK("ident", IDENT_PAUSE, ident_code)
		`CHK("count", m == SW_BOTH ? 7'h00 : 7'h01, rx_count)
		ident_read = 1'b1;
		@(negedge clk);
		ident_read = 1'b0;
		@(negedge clk);
		`CHK("pause", 1'b1, pause_int)
		send(8'h3C);
		quiet();
		if (m == SW_BOTH)
			push(cfg.resume_char_first);
		push(r);
		`CHK("pause", 1'b0, pause_int)
		expect_byte(8'h3C);
		$display("done sw rx");
	endtask
	task automatic t_special();
		base_cfg();
		cfg.enhanced_feature_reg = 8'h20;
		cfg.interrupt_enable_reg = 8'h20;
		do_reset();
		push(cfg.pause_char_second);
		`CHK("pause", 1'b1, pause_int)
		`CHK("halted", 1'b0, tx_halted)
		`CHK("count", 7'h01, rx_count)
		ident_read = 1'b1;
		@(negedge clk);
		ident_read = 1'b0;
		@(negedge clk);
		`CHK("pause", 1'b0, pause_int)
		cfg.enhanced_feature_reg = 8'h02;
		cfg.modem_control_reg = 8'h20;
		push(cfg.pause_char_first);
		`CHK("halted", 1'b1, tx_halted)
		push(8'h41);
		`CHK("halted", 1'b0, tx_halted)
		$display("done special");
	endtask
	task automatic t_sw_tx(input logic [1:0] wl, input logic [1:0] md);
		logic [7:0] hi;
		base_cfg();
		cfg.enhanced_feature_reg = {4'h0, md, 2'h0};
		cfg.fifo_control_reg = 8'h01;
		cfg.flow_threshold_reg = 8'h12;
		cfg.word_len = wl;
		hi = 8'hFF << (5 + wl);
		p = md == SW_SECOND ? cfg.pause_char_second : cfg.pause_char_first;
		r = md == SW_SECOND ? cfg.resume_char_second : cfg.resume_char_first;
		do_reset();
		repeat (9) push(8'h30);
		expect_byte(p | hi);
		if (md == SW_BOTH)
			expect_byte(cfg.pause_char_second | hi);
		drain(4);
		expect_byte(r | hi);
		if (md == SW_BOTH)
			expect_byte(cfg.resume_char_second | hi);
		$display("done sw tx");
	endtask

	initial begin
		base_cfg();
		t_reset();
		t_cts();
		stop_req = 1'b0;
		t_rts(8'h12);
		t_rts(8'h00);
		t_sw_rx(SW_FIRST);
		t_sw_rx(SW_SECOND);
		t_sw_rx(SW_BOTH);
		t_special();
		t_sw_tx(2'h0, SW_FIRST);
		t_sw_tx(2'h3, SW_SECOND);
		t_sw_tx(2'h3, SW_BOTH);
		end_sim();
	end
endmodule
